//--- hall_path_checker_sva.sv
// Port-level assertions for the Hall signal path block
`timescale 1ns/1ps
module hall_path_checker (
  // Clock and reset
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  // APB
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic [7:0]               paddr,
  input  wire logic                     pready,
  input  wire logic                     pslverr,
  // Samples and result
  input  hall_path_pkg::adc_sample_type adc_in,
  input  wire logic                     ref_inject,
  input  wire logic                     out_valid,
  input  wire logic [15:0]              out_data,
  input  hall_path_pkg::diag_out_type   diag_out
);
  import hall_path_pkg::*;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_ZERO_WAIT: assert property (psel && penable |-> pready)
    else $error("access phase without ready");
  AST_UNALIGNED: assert property (psel && penable && paddr[1:0] != 2'b00
    |-> pslverr) else $error("unaligned access not refused");
  AST_SAMPLE_ANSWER: assert property (
    adc_in.valid && !ref_inject |-> ##2 out_valid)
    else $error("signal sample gave no result");
  AST_REF_SILENT: assert property (
    adc_in.valid && ref_inject |-> ##2 !out_valid)
    else $error("reference sample gave a result");
  AST_RESULT_CAUSE: assert property (
    out_valid |-> $past(adc_in.valid, 2) && !$past(ref_inject, 2))
    else $error("result without a signal sample");
  AST_RESULT_HELD: assert property (!out_valid |-> $stable(out_data))
    else $error("result changed without valid");
  AST_REF_SLOT_ENDS: assert property (
    ref_inject && adc_in.valid |=> !ref_inject)
    else $error("reference slot not released");
  AST_SPM_DUTY: assert property (
    diag_out.code == DIAG_SPM && !diag_out.hiz |-> diag_out.duty == DUTY_SPM)
    else $error("monitor duty wrong");
  AST_LOW_DUTY: assert property (
    diag_out.code == DIAG_OOR_LOW && !diag_out.hiz
    |-> diag_out.duty == DUTY_LOW) else $error("low range duty wrong");
  AST_HIGH_DUTY: assert property (
    diag_out.code == DIAG_OOR_HIGH && !diag_out.hiz
    |-> diag_out.duty == DUTY_HIGH) else $error("high range duty wrong");
  AST_HIZ_QUIET: assert property (
    diag_out.hiz |-> diag_out.duty == 10'h000)
    else $error("duty while high impedance");
  AST_IDLE_CODE: assert property (!diag_out.active
    |-> diag_out.code == DIAG_NONE && diag_out.duty == 10'h000)
    else $error("code shown while idle");
endmodule // hall_path_checker

bind hall_signal_path_trim_diag hall_path_checker u_checker (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .paddr(paddr), .pready(pready), .pslverr(pslverr), .adc_in(adc_in),
  .ref_inject(ref_inject), .out_valid(out_valid), .out_data(out_data),
  .diag_out(diag_out));

//--- hall_path_pkg.sv
// Constants, register map and carrier types for the Hall signal path block
package hall_path_pkg;

  // Register byte offsets on APB
  localparam logic [7:0] ADDR_GAIN      = 8'h00;
  localparam logic [7:0] ADDR_OFFSET    = 8'h04;
  localparam logic [7:0] ADDR_CLAMP     = 8'h08;
  localparam logic [7:0] ADDR_GAIN_TC1  = 8'h0c;
  localparam logic [7:0] ADDR_GAIN_TC2  = 8'h10;
  localparam logic [7:0] ADDR_OFS_TC    = 8'h14;
  localparam logic [7:0] ADDR_POST_LIN  = 8'h18;
  localparam logic [7:0] ADDR_DIAG_CFG  = 8'h1c;
  localparam logic [7:0] ADDR_STATUS    = 8'h20;
  localparam logic [7:0] ADDR_OUT       = 8'h24;
  localparam logic [7:0] ADDR_LIN_BASE  = 8'h40;
  localparam int         LIN_POINTS     = 17;

  // Field positions
  localparam int COARSE_LSB      = 0;
  localparam int COARSE_STEP_LSB = 4;
  localparam int UPPER_LSB       = 16;
  localparam int CFG_OV_EN       = 0;
  localparam int CFG_UV_EN       = 1;
  localparam int CFG_OOR_EN      = 2;
  localparam int CFG_SPM_EN      = 3;
  localparam int CFG_TMP_EN      = 4;
  localparam int CFG_HIZ_MODE    = 5;
  localparam int CFG_SPM_ANALOG  = 6;
  localparam int CFG_SPM_DIGITAL = 7;
  localparam int CFG_LIN_INV     = 8;
  localparam int CFG_OUT_INV     = 9;
  localparam int CFG_SPM_RATE    = 12;

  // Reset values
  localparam logic [31:0] GAIN_RST     = 32'h0400_0000;
  localparam logic [31:0] CLAMP_RST    = 32'h0fff_0000;
  localparam logic [31:0] POST_LIN_RST = 32'h0000_0fff;
  localparam logic [31:0] DIAG_CFG_RST = 32'h0000_709f;

  // Arithmetic scaling
  localparam int FINE_UNITY    = 1024;
  localparam int FINE_SH       = 11;
  localparam int TC1_HOT_SH    = 7;
  localparam int TC1_COLD_SH   = 8;
  localparam int TC2_HOT_SH    = 0;
  localparam int TC2_COLD_SH   = 2;
  localparam int CORR_SH       = 25;
  localparam int OFS_HOT_SH    = 4;
  localparam int OFS_COLD_SH   = 3;
  localparam int MID_SCALE     = 32768;
  localparam int FULL_SCALE    = 65535;
  localparam int LIN_FRAC_W    = 12;
  localparam int COEF_SH       = 3;
  localparam int LIN_STEP      = 512;
  localparam int LIN_BIAS      = 4096;
  localparam int POST_GAIN_SH  = 12;
  localparam int LIMIT_SH      = 4;
  localparam int HIGH_LIMIT_MIN = 16;

  // Temperatures in degrees C
  localparam int TEMP_REF_C  = 25;
  localparam int TEMP_HOT_C  = 160;
  localparam int TEMP_COLD_C = -55;

  // Monitor reference window in converter codes
  localparam int SPM_REF_EXPECT = 16384;
  localparam int SPM_REF_TOL    = 1024;

  // Converter full-scale codes
  localparam logic [15:0] ADC_MAX_CODE = 16'h7fff;
  localparam logic [15:0] ADC_MIN_CODE = 16'h8000;

  // Diagnostic PWM duty, in tenths of a percent
  localparam logic [9:0] DUTY_OV   = 10'd404;
  localparam logic [9:0] DUTY_UV   = 10'd116;
  localparam logic [9:0] DUTY_SPM  = 10'd308;
  localparam logic [9:0] DUTY_HOT  = 10'd500;
  localparam logic [9:0] DUTY_COLD = 10'd596;
  localparam logic [9:0] DUTY_LOW  = 10'd692;
  localparam logic [9:0] DUTY_HIGH = 10'd788;

  typedef enum logic [2:0] {
    DIAG_NONE, DIAG_OV, DIAG_UV, DIAG_SPM,
    DIAG_TEMP_HOT, DIAG_TEMP_COLD, DIAG_OOR_LOW, DIAG_OOR_HIGH
  } diag_code_type;

  typedef struct packed {
    logic        valid;
    logic [15:0] data;
  } adc_sample_type;

  typedef struct packed {
    logic          active;
    diag_code_type code;
    logic [9:0]    duty;
    logic          hiz;
  } diag_out_type;

endpackage

//--- hall_signal_path_trim_diag.sv
// Trim, compensation, linearization, clamp and diagnostics of the sensor path
//
// Design decisions made here: the address map and the APB slave port.
`timescale 1ns/1ps

module hall_signal_path_trim_diag (
  // APB slave
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [7:0]                  paddr,
  input  wire logic [31:0]                 pwdata,
  output logic [31:0]                      prdata,
  output logic                             pready,
  output logic                             pslverr,
  // Converter and temperature sensor
  input  hall_path_pkg::adc_sample_type    adc_in,
  input  wire logic signed [8:0]           temp_c,
  output logic                             ref_inject,
  // Supply detectors, asynchronous
  input  wire logic                        ov_detect,
  input  wire logic                        uv_detect,
  // Result towards the output framer
  output logic                             out_valid,
  output logic [15:0]                      out_data,
  output hall_path_pkg::diag_out_type      diag_out
);
  import hall_path_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  logic [31:0] gain_reg, offset_reg, clamp_reg, gain_tc1_reg, gain_tc2_reg;
  logic [31:0] ofs_tc_reg, post_lin_reg, diag_cfg_reg;
  logic [12:0] lin_coef_reg [LIN_POINTS];
  logic        wr_en;
  logic [2:0]  sync2_reg [2];
  logic [1:0]  supply_reg;

  function automatic logic addr_valid(input logic [7:0] a);
    addr_valid = (a <= ADDR_OUT && a[1:0] == 2'b00) ||
                 (a >= ADDR_LIN_BASE && a[1:0] == 2'b00 &&
                  a < ADDR_LIN_BASE + 8'(LIN_POINTS * 4));
  endfunction

  function automatic logic [4:0] lin_index(input logic [7:0] a);
    logic [7:0] d;
    d = a - ADDR_LIN_BASE;
    lin_index = d[6:2];
  endfunction

  assign wr_en   = psel && penable && pwrite && addr_valid(paddr);
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !addr_valid(paddr);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gain_reg     <= GAIN_RST;
      offset_reg   <= '0;
      clamp_reg    <= CLAMP_RST;
      gain_tc1_reg <= '0;
      gain_tc2_reg <= '0;
      ofs_tc_reg   <= '0;
      post_lin_reg <= POST_LIN_RST;
      diag_cfg_reg <= DIAG_CFG_RST;
    end else if (wr_en) begin
      case (paddr)
        ADDR_GAIN:     gain_reg     <= pwdata;
        ADDR_OFFSET:   offset_reg   <= pwdata;
        ADDR_CLAMP:    clamp_reg    <= pwdata;
        ADDR_GAIN_TC1: gain_tc1_reg <= pwdata;
        ADDR_GAIN_TC2: gain_tc2_reg <= pwdata;
        ADDR_OFS_TC:   ofs_tc_reg   <= pwdata;
        ADDR_POST_LIN: post_lin_reg <= pwdata;
        ADDR_DIAG_CFG: diag_cfg_reg <= pwdata;
        default: ;
      endcase
    end
  end

  // Breakpoint table, reset to a straight line
  for (genvar i = 0; i < LIN_POINTS; i++) begin : g_lin
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        // Top point saturates: it would not fit 13 signed bits
        lin_coef_reg[i] <= (i * LIN_STEP - LIN_BIAS >= LIN_BIAS) ?
                           13'(LIN_BIAS - 1) : 13'(i * LIN_STEP - LIN_BIAS);
      end else if (wr_en && paddr >= ADDR_LIN_BASE &&
                   lin_index(paddr) == 5'(i)) begin
        lin_coef_reg[i] <= pwdata[12:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Detector inputs: three stages, accept when last two agree
  logic [1:0] det_in;
  assign det_in = {uv_detect, ov_detect};

  for (genvar i = 0; i < 2; i++) begin : g_sync
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        sync2_reg[i]  <= '0;
        supply_reg[i] <= 1'b0;
      end else begin
        sync2_reg[i] <= {sync2_reg[i][1:0], det_in[i]};
        if (sync2_reg[i][2] == sync2_reg[i][1]) begin
          supply_reg[i] <= sync2_reg[i][2];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Front path: gain, temperature compensation, offset
  logic               hot;
  logic signed [47:0] x_s, dt, coarse_mult, fine_mult, y1, y1_chk;
  logic signed [47:0] c1, c2, oc, corr, y2, y3;
  logic signed [79:0] prod;
  logic [1:0]         step;

  always_comb begin
    x_s  = 48'(signed'(adc_in.data));
    dt   = 48'(temp_c) - 48'(TEMP_REF_C);
    hot  = dt > 48'sd0;
    step = gain_reg[COARSE_STEP_LSB+:2] == 2'd3 ? 2'd2
         : gain_reg[COARSE_STEP_LSB+:2];
    coarse_mult = (48'(gain_reg[COARSE_LSB+:3]) + 48'sd1) <<< step;
    fine_mult   = 48'(FINE_UNITY) + 48'(gain_reg[UPPER_LSB+:11]);
    y1     = (x_s * coarse_mult * fine_mult) >>> FINE_SH;
    y1_chk = (((x_s * fine_mult) <<< step) *
              signed'(48'(gain_reg[COARSE_LSB+:3]) + 48'sd1))
             >>> FINE_SH;
    if (hot) begin
      c1 = 48'(signed'(gain_tc1_reg[10:0])) <<< TC1_HOT_SH;
      c2 = 48'(signed'(gain_tc2_reg[9:0])) <<< TC2_HOT_SH;
      oc = (48'(signed'(ofs_tc_reg[11:0])) * dt) >>> OFS_HOT_SH;
    end else begin
      c1 = 48'(signed'(gain_tc1_reg[UPPER_LSB+:11])) <<< TC1_COLD_SH;
      c2 = 48'(signed'(gain_tc2_reg[UPPER_LSB+:10])) <<< TC2_COLD_SH;
      oc = (48'(signed'(ofs_tc_reg[UPPER_LSB+:12])) * dt)
           >>> OFS_COLD_SH;
    end
    corr = c1 * dt + c2 * dt * dt;
    prod = 80'(y1) * 80'(corr);
    y2   = y1 + 48'(prod >>> CORR_SH);
    y3   = y2 + 48'(signed'(offset_reg[17:0])) + oc +
           48'(MID_SCALE);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Monitor slot scheduling and reference check
  logic [3:0] slot_cnt_reg;
  logic       ref_slot_reg, spm_ana_err_reg, spm_dig_err_reg;
  logic       take_sig, take_ref;
  logic signed [47:0] ref_dev;

  assign take_ref = adc_in.valid && ref_slot_reg;
  assign take_sig = adc_in.valid && !ref_slot_reg;
  assign ref_inject = ref_slot_reg;
  assign ref_dev  = x_s - 48'(SPM_REF_EXPECT);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slot_cnt_reg <= '0;
      ref_slot_reg <= 1'b0;
    end else if (!diag_cfg_reg[CFG_SPM_ANALOG]) begin
      slot_cnt_reg <= '0;
      ref_slot_reg <= 1'b0;
    end else if (take_ref) begin
      ref_slot_reg <= 1'b0;
    end else if (take_sig) begin
      if (slot_cnt_reg == diag_cfg_reg[CFG_SPM_RATE+:4]) begin
        slot_cnt_reg <= '0;
        ref_slot_reg <= 1'b1;
      end else begin
        slot_cnt_reg <= slot_cnt_reg + 4'h1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      spm_ana_err_reg <= 1'b0;
      spm_dig_err_reg <= 1'b0;
    end else begin
      if (!diag_cfg_reg[CFG_SPM_ANALOG]) begin
        spm_ana_err_reg <= 1'b0;
      end else if (take_ref) begin
        spm_ana_err_reg <= ref_dev > 48'(SPM_REF_TOL) ||
                           ref_dev < -48'(SPM_REF_TOL);
      end
      if (!diag_cfg_reg[CFG_SPM_DIGITAL]) begin
        spm_dig_err_reg <= 1'b0;
      end else if (take_sig) begin
        spm_dig_err_reg <= y1 != y1_chk;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Stage one: saturate into output range, note overrange
  logic [15:0] front_reg;
  logic        front_valid_reg, oor_lo_reg, oor_hi_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      front_reg       <= 16'(MID_SCALE);
      front_valid_reg <= 1'b0;
      oor_lo_reg      <= 1'b0;
      oor_hi_reg      <= 1'b0;
    end else begin
      front_valid_reg <= take_sig;
      if (take_sig) begin
        if (y3 < 48'sd0) begin
          front_reg <= '0;
        end else if (y3 > 48'(FULL_SCALE)) begin
          front_reg <= 16'(FULL_SCALE);
        end else begin
          front_reg <= y3[15:0];
        end
        oor_lo_reg <= y3 < 48'sd0 || adc_in.data == ADC_MIN_CODE;
        oor_hi_reg <= y3 > 48'(FULL_SCALE) ||
                      adc_in.data == ADC_MAX_CODE;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Stage two: linearize, post trims, inversion, clamp
  logic [15:0]        lin_in;
  logic [4:0]         seg;
  logic signed [47:0] k0, k1, lin_v, post_v, fin_v, lo_lim, hi_lim;

  always_comb begin
    lin_in = diag_cfg_reg[CFG_LIN_INV] ? ~front_reg : front_reg;
    seg    = 5'(lin_in[15:LIN_FRAC_W]);
    k0     = 48'(signed'(lin_coef_reg[seg])) <<< COEF_SH;
    k1     = 48'(signed'(lin_coef_reg[seg + 5'd1])) <<< COEF_SH;
    lin_v  = k0 + (((k1 - k0) * signed'(48'(lin_in[LIN_FRAC_W-1:0])))
                   >>> LIN_FRAC_W);
    post_v = ((lin_v * 48'(signed'(post_lin_reg[12:0])))
              >>> POST_GAIN_SH) +
             (48'(signed'(post_lin_reg[UPPER_LSB+:12])) <<< LIMIT_SH) +
             48'(MID_SCALE);
    fin_v  = diag_cfg_reg[CFG_OUT_INV] ? 48'(FULL_SCALE) - post_v
           : post_v;
    lo_lim = 48'(clamp_reg[11:0]) <<< LIMIT_SH;
    hi_lim = clamp_reg[UPPER_LSB+:12] == 12'h000 ? 48'(HIGH_LIMIT_MIN)
           : 48'({clamp_reg[UPPER_LSB+:12], 4'hf});
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_valid <= 1'b0;
      out_data  <= 16'(MID_SCALE);
    end else begin
      out_valid <= front_valid_reg;
      if (front_valid_reg) begin
        if (fin_v < lo_lim) begin
          out_data <= lo_lim[15:0];
        end else if (fin_v > hi_lim) begin
          out_data <= hi_lim[15:0];
        end else begin
          out_data <= fin_v[15:0];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Diagnostic selection, highest priority first
  logic          tmp_hot, tmp_cold;
  diag_code_type code_next;
  logic [9:0]    duty_next;

  assign tmp_hot  = temp_c > 9'(TEMP_HOT_C);
  assign tmp_cold = temp_c < 9'(TEMP_COLD_C);

  always_comb begin
    code_next = DIAG_NONE;
    if (diag_cfg_reg[CFG_OV_EN] && supply_reg[0]) begin
      code_next = DIAG_OV;
    end else if (diag_cfg_reg[CFG_UV_EN] && supply_reg[1]) begin
      code_next = DIAG_UV;
    end else if (diag_cfg_reg[CFG_SPM_EN] &&
                 (spm_ana_err_reg || spm_dig_err_reg)) begin
      code_next = DIAG_SPM;
    end else if (diag_cfg_reg[CFG_TMP_EN] && tmp_hot) begin
      code_next = DIAG_TEMP_HOT;
    end else if (diag_cfg_reg[CFG_TMP_EN] && tmp_cold) begin
      code_next = DIAG_TEMP_COLD;
    end else if (diag_cfg_reg[CFG_OOR_EN] && oor_lo_reg) begin
      code_next = DIAG_OOR_LOW;
    end else if (diag_cfg_reg[CFG_OOR_EN] && oor_hi_reg) begin
      code_next = DIAG_OOR_HIGH;
    end
    case (code_next)
      DIAG_OV:        duty_next = DUTY_OV;
      DIAG_UV:        duty_next = DUTY_UV;
      DIAG_SPM:       duty_next = DUTY_SPM;
      DIAG_TEMP_HOT:  duty_next = DUTY_HOT;
      DIAG_TEMP_COLD: duty_next = DUTY_COLD;
      DIAG_OOR_LOW:   duty_next = DUTY_LOW;
      DIAG_OOR_HIGH:  duty_next = DUTY_HIGH;
      default:        duty_next = '0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      diag_out <= '{active: 1'b0, code: DIAG_NONE, duty: '0, hiz: 1'b0};
    end else begin
      diag_out.code   <= code_next;
      diag_out.active <= code_next != DIAG_NONE;
      diag_out.duty   <= diag_cfg_reg[CFG_HIZ_MODE] ? '0 : duty_next;
      diag_out.hiz    <= code_next != DIAG_NONE &&
                         diag_cfg_reg[CFG_HIZ_MODE];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB read data, captured in the setup cycle
  logic [31:0] rd_word;
  logic [7:0]  status_bits;

  assign status_bits = {diag_out.code == DIAG_OOR_HIGH,
                        diag_out.code == DIAG_OOR_LOW,
                        tmp_hot || tmp_cold, supply_reg[0], supply_reg[1],
                        spm_ana_err_reg || spm_dig_err_reg,
                        spm_dig_err_reg, spm_ana_err_reg};

  always_comb begin
    rd_word = '0;
    case (paddr)
      ADDR_GAIN:     rd_word = gain_reg;
      ADDR_OFFSET:   rd_word = offset_reg;
      ADDR_CLAMP:    rd_word = clamp_reg;
      ADDR_GAIN_TC1: rd_word = gain_tc1_reg;
      ADDR_GAIN_TC2: rd_word = gain_tc2_reg;
      ADDR_OFS_TC:   rd_word = ofs_tc_reg;
      ADDR_POST_LIN: rd_word = post_lin_reg;
      ADDR_DIAG_CFG: rd_word = diag_cfg_reg;
      ADDR_STATUS:   rd_word = {23'h0, ref_slot_reg, status_bits};
      ADDR_OUT:      rd_word = {16'h0, out_data};
      default: begin
        if (addr_valid(paddr)) begin
          rd_word = {19'h0, lin_coef_reg[lin_index(paddr)]};
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (psel && !penable) begin
      prdata <= rd_word;
    end
  end

endmodule // hall_signal_path_trim_diag

//--- host_result_receiver.sv
// Host receiver model collecting results and the diagnostic duty
`timescale 1ns/1ps
module host_result_receiver (
  // Clock and reset
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  // Result from the block
  input  wire logic                   out_valid,
  input  wire logic [15:0]            out_data,
  input  hall_path_pkg::diag_out_type diag_out,
  // Decoded view
  output logic [15:0]                 last_data,
  output logic [15:0]                 frame_count,
  output logic [9:0]                  last_duty
);
  import hall_path_pkg::*;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_data <= 16'h0000;
      frame_count <= 16'h0000;
    end else if (out_valid) begin
      last_data <= out_data;
      frame_count <= frame_count + 16'h0001;
    end
  end
  // Line released when high impedance: no carrier seen
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      last_duty <= 10'h000;
    else
      last_duty <= diag_out.hiz ? 10'h000 : diag_out.duty;
  end
endmodule // host_result_receiver

//--- test_hall_signal_path_trim_diag.sv
// Self-checking bench for the Hall signal path block
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin \
  err_total++; $display("CHECK FAILED %s exp %0h got %0h", nm, ex, got); \
  end end
module test_hall_signal_path_trim_diag;
  import hall_path_pkg::*;
  logic              pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]        paddr;
  logic [31:0]       pwdata, prdata, rd;
  logic              er, ref_inject, ov_detect, uv_detect, out_valid;
  logic signed [8:0] temp_c;
  logic [15:0]       out_data, rx_data, rx_count, cnt;
  logic [9:0]        rx_duty;
  adc_sample_type    adc_in;
  diag_out_type      diag_out;
  int                err_total, num_checks, cyc;

  hall_signal_path_trim_diag DUT (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .adc_in(adc_in), .temp_c(temp_c), .ref_inject(ref_inject),
    .ov_detect(ov_detect), .uv_detect(uv_detect), .out_valid(out_valid),
    .out_data(out_data), .diag_out(diag_out));
  host_result_receiver rx (.pclk(pclk), .presetn(presetn),
    .out_valid(out_valid), .out_data(out_data), .diag_out(diag_out),
    .last_data(rx_data), .frame_count(rx_count), .last_duty(rx_duty));

  always #20 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      results();
    end
  end

  task automatic results();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic sample(input logic [15:0] d);
    @(posedge pclk);
    adc_in <= '{valid: 1'b1, data: d};
    @(posedge pclk);
    adc_in.valid <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask

  task automatic t_regs();
    apb(1'b0, ADDR_GAIN, 32'h0);
    `CHK("gain reset", GAIN_RST, rd)
    apb(1'b0, ADDR_CLAMP, 32'h0);
    `CHK("clamp reset", CLAMP_RST, rd)
    apb(1'b0, ADDR_POST_LIN, 32'h0);
    `CHK("post gain reset", POST_LIN_RST, rd)
    apb(1'b0, ADDR_DIAG_CFG, 32'h0);
    `CHK("config reset", DIAG_CFG_RST, rd)
    apb(1'b0, 8'h28, 32'h0);
    `CHK("unmapped error", 1'b1, er)
    `CHK("unmapped data", 32'h0, rd)
    apb(1'b1, ADDR_OFFSET, 32'h0002_0000);
    apb(1'b0, ADDR_OFFSET, 32'h0);
    `CHK("offset readback", 32'h0002_0000, rd)
    apb(1'b1, ADDR_OFFSET, 32'h0);
  endtask

  task automatic t_clamp();
    apb(1'b1, ADDR_CLAMP, 32'h0a00_0100);
    sample(16'h0000);
    `CHK("quiescent", 16'h8000, rx_data)
    sample(16'h7fff);
    `CHK("high clamp", 16'ha00f, rx_data)
    `CHK("high range code", DIAG_OOR_HIGH, diag_out.code)
    `CHK("high range duty", DUTY_HIGH, rx_duty)
    sample(16'h8000);
    `CHK("low clamp", 16'h1000, rx_data)
    `CHK("low range code", DIAG_OOR_LOW, diag_out.code)
    `CHK("low range duty", DUTY_LOW, rx_duty)
    apb(1'b1, ADDR_DIAG_CFG, DIAG_CFG_RST | 32'h0000_0200);
    sample(16'h7fff);
    `CHK("inverted clamp", 16'h1000, rx_data)
    apb(1'b1, ADDR_DIAG_CFG, DIAG_CFG_RST | 32'h0000_0100);
    sample(16'h7fff);
    `CHK("input inverted", 16'h1000, rx_data)
    apb(1'b1, ADDR_DIAG_CFG, DIAG_CFG_RST & ~32'h0000_0004);
    sample(16'h7fff);
    `CHK("range check off", 1'b0, diag_out.active)
    apb(1'b1, ADDR_DIAG_CFG, DIAG_CFG_RST | 32'h0000_0020);
    sample(16'h7fff);
    `CHK("hiz flag", 1'b1, diag_out.hiz)
    `CHK("hiz duty", 10'h000, rx_duty)
  endtask

  task automatic t_supply_temp();
    apb(1'b1, ADDR_DIAG_CFG, DIAG_CFG_RST);
    ov_detect <= 1'b1;
    repeat (8) @(posedge pclk);
    `CHK("ov code", DIAG_OV, diag_out.code)
    `CHK("ov duty", DUTY_OV, rx_duty)
    apb(1'b1, ADDR_DIAG_CFG, DIAG_CFG_RST & ~32'h0000_0001);
    repeat (6) @(posedge pclk);
    `CHK("ov masked", 1'b0, diag_out.code == DIAG_OV)
    ov_detect <= 1'b0;
    temp_c <= 9'sd170;
    repeat (6) @(posedge pclk);
    `CHK("hot code", DIAG_TEMP_HOT, diag_out.code)
    `CHK("hot duty", DUTY_HOT, rx_duty)
    temp_c <= -9'sd60;
    repeat (3) @(posedge pclk);
    `CHK("cold code", DIAG_TEMP_COLD, diag_out.code)
    temp_c <= 9'sd25;
    uv_detect <= 1'b1;
    repeat (8) @(posedge pclk);
    `CHK("uv code", DIAG_UV, diag_out.code)
    uv_detect <= 1'b0;
    repeat (8) @(posedge pclk);
  endtask

  task automatic t_monitor();
    int n;
    apb(1'b1, ADDR_CLAMP, CLAMP_RST);
    apb(1'b1, ADDR_DIAG_CFG, (DIAG_CFG_RST & ~32'h0000_f000) | 32'h40);
    for (n = 0; n < 4 && ref_inject !== 1'b1; n++)
      sample(16'h0000);
    cnt = rx_count;
    sample(16'(SPM_REF_EXPECT));
    `CHK("reference no frame", cnt, rx_count)
    `CHK("reference good", 1'b0, diag_out.code == DIAG_SPM)
    sample(16'h0000);
    `CHK("slot after one", 1'b1, ref_inject)
    sample(16'h0000);
    `CHK("monitor code", DIAG_SPM, diag_out.code)
    `CHK("monitor duty", DUTY_SPM, rx_duty)
    apb(1'b1, ADDR_DIAG_CFG, DIAG_CFG_RST);
  endtask

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    adc_in = '0;
    temp_c = 9'sd25;
    ov_detect = 1'b0;
    uv_detect = 1'b0;
    err_total = 0;
    num_checks = 0;
    cyc = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_clamp();
    t_supply_temp();
    t_monitor();
    results();
  end
endmodule // test_hall_signal_path_trim_diag
